// ===== rtl/pixel_clock_load_divider.sv
// Pixel clock pass-through, load dividers, gated loads and APB status/control
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "pixclk_cfg.svh"
module pixel_clock_load_divider
  import pixclk_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_in,
  input wire logic factor_sel0,
  input wire logic factor_sel1,
  input wire logic enable_sync,
  input wire logic enable_async,
  input wire logic align_in,
  output logic clk_true,
  output logic clk_comp,
  output load_bus_t loads
);
  logic osc_prev;
  logic align_prev;
  logic [3:0] cnt;
  logic [1:0] active_sel;
  logic [1:0] qcnt;
  logic load_a;
  logic load_half;
  logic load_quarter;
  logic en_s_sync;
  logic live_c;
  logic held_c;
  logic armed;
  logic stopped;
  logic [2:0] ctrl;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Oscillator waveform arrives as a sampled level; each rise is one pixel period
  wire osc_rise = osc_in & ~osc_prev;
  wire [1:0] pin_sel = {factor_sel1, factor_sel0};
  wire [1:0] want_sel = ctrl[`CTRL_USE_REG_BIT] ? ctrl[2:1] : pin_sel;

  // Factor table: total cycles and low cycles per load period
  logic [3:0] total;
  logic [3:0] low;
  always_comb begin
    unique case (factor_sel_t'(active_sel))
      factor3: begin
        total = {1'b0, `FACTOR3_TOTAL};
        low = {1'b0, `FACTOR3_LOW};
      end
      factor4: begin
        total = {1'b0, `FACTOR4_TOTAL};
        low = {1'b0, `FACTOR4_LOW};
      end
      factor5: begin
        total = {1'b0, `FACTOR5_TOTAL};
        low = {1'b0, `FACTOR5_LOW};
      end
      factor8: begin
        total = `FACTOR8_TOTAL;
        low = {1'b0, `FACTOR8_LOW};
      end
    endcase
  end

  // New factor is taken only at a period boundary so no runt load pulse appears
  wire wrap = osc_rise & (cnt == total - 4'h1);
  wire [3:0] cnt_inc = cnt + 4'h1;
  wire [3:0] next_cnt = wrap ? 4'h0 : (osc_rise ? cnt_inc : cnt);
  wire next_load_a = osc_rise ? (~wrap & (cnt_inc >= low)) : load_a;
  wire la_rise = next_load_a & ~load_a;
  wire [1:0] next_qcnt = la_rise ? qcnt + 2'h1 : qcnt;
  wire quarter_rise = la_rise & (qcnt == 2'h1);
  wire next_en_s = la_rise ? enable_sync : en_s_sync;
  wire next_live_c = next_en_s & next_load_a;
  wire align_edge = (align_in & ~align_prev) | (psel & penable & pwrite
    & (paddr == `CTRL_OFFSET) & pwdata[`CTRL_ALIGN_BIT]);
  // Stop at the first quarter rise after the edge, resume at the next one
  wire next_stopped = quarter_rise ? (armed & ~stopped) : stopped;
  wire next_armed = quarter_rise ? 1'b0 : (armed | align_edge);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev <= 1'b0;
      align_prev <= 1'b0;
      cnt <= 4'h0;
      active_sel <= 2'b00;
      load_a <= 1'b0;
      qcnt <= 2'h0;
      load_half <= 1'b0;
      load_quarter <= 1'b0;
      en_s_sync <= 1'b0;
      live_c <= 1'b0;
      held_c <= 1'b0;
      armed <= 1'b0;
      stopped <= 1'b0;
      clk_true <= 1'b0;
      clk_comp <= 1'b1;
    end else begin
      osc_prev <= osc_in;
      align_prev <= align_in;
      cnt <= next_cnt;
      if (wrap) begin
        active_sel <= want_sel;
      end
      load_a <= next_load_a;
      qcnt <= next_qcnt;
      load_half <= next_qcnt[0];
      load_quarter <= next_qcnt[1];
      en_s_sync <= next_en_s;
      live_c <= next_live_c;
      // Track the value the output shows, so the switch to the frozen copy cannot glitch
      if (enable_async) begin
        held_c <= next_live_c;
      end
      armed <= next_armed;
      stopped <= next_stopped;
      // Stop lands on an oscillator high phase, so the true output never glitches
      clk_true <= next_stopped | osc_in;
      clk_comp <= ~(next_stopped | osc_in);
    end
  end

  // Async enable low picks the frozen copy at once; the mux takes enable_async directly, with no input sample
  wire gated = enable_async ? live_c : held_c;
  // One driver for the whole bundle; field order follows the packed struct
  assign loads = {load_a, load_a, gated, gated, load_half, load_quarter};

  // APB slave: zero wait states, unmapped addresses answer with pslverr
  wire hit_ctrl = paddr == `CTRL_OFFSET;
  wire hit_status = paddr == `STATUS_OFFSET;
  wire setup = psel & ~penable;
  wire [31:0] status_word = {24'h000000, load_quarter, load_half, load_a,
    active_sel, en_s_sync, armed, stopped};
  wire [31:0] read_word = hit_ctrl ? {29'h00000000, ctrl} :
    (hit_status ? status_word : 32'h00000000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 3'(`CTRL_RESET);
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      if (psel & penable & pwrite & hit_ctrl) begin
        ctrl <= pwdata[2:0];
      end
      if (setup) begin
        prdata_q <= pwrite ? 32'h00000000 : read_word;
        pslverr_q <= ~(hit_ctrl | hit_status);
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q & psel & penable;
endmodule

// ===== pkg/pixclk_cfg.svh
// Constants for the pixel clock and load divider block
// Notes on behaviour
// - Select pair picks factor 3/4/5/8, fixed low/high; with CTRL_USE_REG_BIT set, ctrl[2:1] picks instead
// - load_a and load_b divide pixel clock by factor
// - load_half is load_a divided by two
// - load_quarter is load_a divided by four
// - Pixel clock runs at oscillator rate unless stopped
// - Sync enable is sampled on load_a rising edge
// - Sync enable low holds load_c, load_d low
// - Async enable low freezes load_c, load_d immediately
// - Both enables high: gated loads match load_a/load_b
// - Align edge: stop clock high at quarter rise
// - Restart pixel clock at next load_quarter rise
`ifndef PIXCLK_CFG_SVH
`define PIXCLK_CFG_SVH
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define CTRL_RESET 32'h00000000
`define CTRL_USE_REG_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_ALIGN_BIT 3
`define FACTOR3_TOTAL 3'h3
`define FACTOR3_LOW 3'h1
`define FACTOR4_TOTAL 3'h4
`define FACTOR4_LOW 3'h2
`define FACTOR5_TOTAL 3'h5
`define FACTOR5_LOW 3'h2
`define FACTOR8_TOTAL 4'h8
`define FACTOR8_LOW 3'h4
`endif

// ===== pkg/pixclk_pkg.sv
// Types for the pixel clock and load divider block
package pixclk_pkg;
  typedef enum logic [1:0] {
    factor3 = 2'b00,
    factor4 = 2'b01,
    factor5 = 2'b10,
    factor8 = 2'b11
  } factor_sel_t;
  typedef struct packed {
    logic load_a;
    logic load_b;
    logic load_c;
    logic load_d;
    logic load_half;
    logic load_quarter;
  } load_bus_t;
endpackage

// ===== test/pixclk_assertions.sv
// Checker on clock and load outputs
`timescale 1ns/10ps
module pixclk_chk
  import pixclk_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_in,
  input wire logic enable_async,
  input wire logic clk_true,
  input wire logic clk_comp,
  input wire load_bus_t loads
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_CMP: assert property (clk_comp != clk_true) else $error("pair");
  AST_CLK: assert property ($past(presetn) && !clk_true |-> !$past(osc_in))
    else $error("clk");
  AST_LDB: assert property (loads.load_b == loads.load_a) else $error("ldb");
  AST_LDD: assert property (loads.load_d == loads.load_c) else $error("ldd");
  AST_GATE: assert property (enable_async && $past(enable_async) && $rose(loads.load_c)
    |-> $rose(loads.load_a)) else $error("gate");
  AST_FRZ: assert property (!enable_async && !$past(enable_async) |-> $stable(loads.load_c))
    else $error("frz");
  AST_HALF: assert property ($changed(loads.load_half) |-> $rose(loads.load_a))
    else $error("half");
  AST_QTR: assert property ($changed(loads.load_quarter) |-> $fell(loads.load_half))
    else $error("qtr");
endmodule
bind pixel_clock_load_divider pixclk_chk chk (.pclk, .presetn, .osc_in, .enable_async,
  .clk_true, .clk_comp, .loads);

// ===== test/osc_src.sv
// Oscillator model feeding the pixel clock input
`timescale 1ns/10ps
module osc_src (
  input wire logic pclk,
  output logic osc_in
);
  // Half rate: every osc period spans two samples
  initial osc_in = 1'h0;
  always @(posedge pclk) osc_in <= ~osc_in;
endmodule

// ===== test/test_pixel_clock_load_divider.sv
// Bench for the pixel clock and load divider
`timescale 1ns/10ps
module test_pixel_clock_load_divider;
  import pixclk_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_in, er;
  logic factor_sel0, factor_sel1, enable_sync, enable_async, align_in, clk_true, clk_comp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  load_bus_t loads;
  int fails, num_checks, seed, n, m, run, best;
  int lo[4] = '{1, 2, 2, 4};
  int hi[4] = '{2, 2, 3, 4};
  pixel_clock_load_divider uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .osc_in, .factor_sel0, .factor_sel1, .enable_sync,
    .enable_async, .align_in, .clk_true, .clk_comp, .loads);
  osc_src osc (.pclk, .osc_in);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %0h not %0h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task rise;
    while (loads.load_a !== 1'h0) @(posedge pclk);
    while (loads.load_a !== 1'h1) @(posedge pclk);
  endtask
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
  initial begin
    seed = 63283;
    {presetn, psel, penable, pwrite, paddr, pwdata, align_in} = '0;
    {factor_sel1, factor_sel0, enable_sync, enable_async} = 4'h3;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    for (int f = 0; f < 4; f++) begin
      {factor_sel1, factor_sel0} <= f[1:0];
      rise();
      rise();
      for (n = 0; loads.load_a === 1'h1; n++) @(posedge pclk);
      for (m = 0; loads.load_a === 1'h0; m++) @(posedge pclk);
      chk(n, 2 * hi[f]);
      chk(m, 2 * lo[f]);
    end
    enable_sync <= 1'h0;
    rise();
    rise();
    repeat (40) begin
      @(posedge pclk);
      chk(loads.load_c, 0);
    end
    enable_sync <= 1'h1;
    rise();
    rise();
    repeat ($random(seed) & 15) @(posedge pclk);
    enable_async <= 1'h0;
    repeat (2) @(posedge pclk);
    er = loads.load_c;
    repeat (20) begin
      @(posedge pclk);
      chk(loads.load_c, er);
    end
    enable_async <= 1'h1;
    align_in <= 1'h1;
    best = 0;
    run = 0;
    repeat (200) begin
      @(posedge pclk);
      run = (clk_true === 1'h1) ? run + 1 : 0;
      if (run > best) best = run;
    end
    chk(best >= 64 && best <= 66, 1);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd[4:3], 3);
    apb(1'h1, 12'h000, 32'h3);
    // New select is only taken at a load period boundary
    repeat (40) @(posedge pclk);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd[4:3], 1);
    apb(1'h0, 12'h010, 32'h0);
    chk(er, 1);
    chk(rd, 0);
    wrap_up;
  end
endmodule
